/* File: bod_pkg.sv */
package bod_pkg;

    // instruction word and operand widths
    localparam int unsigned INSTR_W      = 14;          // one word holds opcode and operands
    localparam int unsigned FADDR_W      = 7;           // file register select width
    localparam int unsigned DATA_W       = 8;           // file register width
    localparam int unsigned BITPOS_W     = 3;           // bit position width
    localparam int unsigned REL_W        = 9;           // signed relative jump literal width
    localparam int unsigned PC_W_DEF     = 15;          // default program counter width

    // timing: core clocks per instruction cycle
    localparam int unsigned CLK_PER_ICYC = 4;

    // field positions inside the instruction word
    localparam int unsigned F_LSB        = 0;
    localparam int unsigned BITPOS_LSB   = 7;
    localparam int unsigned DEST_POS     = 7;
    localparam int unsigned REL_LSB      = 0;
    localparam int unsigned PTR_POS      = 2;

    // opcode masks and match values; masked-out bits are don't-care
    localparam logic [13:0] BITOP_MASK   = 14'h3c00;
    localparam logic [13:0] BCLR_VAL     = 14'h1000;
    localparam logic [13:0] SKZ_VAL      = 14'h1800;
    localparam logic [13:0] SKO_VAL      = 14'h1c00;
    localparam logic [13:0] RJMP_MASK    = 14'h3e00;
    localparam logic [13:0] RJMP_VAL     = 14'h3200;
    localparam logic [13:0] FCOPY_MASK   = 14'h3f00;
    localparam logic [13:0] FCOPY_VAL    = 14'h0800;

    // reset values
    localparam logic [13:0] IR_RST       = 14'h0000;    // decodes as idle
    localparam logic [7:0]  DATA_RST     = 8'h00;
    localparam logic [6:0]  FADDR_RST    = 7'h00;

    // decoded operation classes
    typedef enum logic [2:0] {
        idle_op,
        bit_clear_op,
        skip_if_zero_op,
        skip_if_one_op,
        relative_jump_op,
        file_copy_op
    } bod_op_t;

    // instruction cycle phases
    typedef enum logic [1:0] {
        PH_DEC,
        PH_RD,
        PH_MOD,
        PH_WB
    } bod_phase_t;

    // masked opcode compare, used for every class except idle, which is the fall-through
    function automatic logic bod_match(input logic [13:0] word, input logic [13:0] mask, input logic [13:0] val);
        return (word & mask) == val;
    endfunction : bod_match

endpackage : bod_pkg

/* File: bod_dec_if.sv */
`timescale 1ns/1ps
// carries the current instruction word to the field decoder and its fields back
interface bod_dec_if;
    import bod_pkg::*;
    logic [13:0]          word;       // instruction under execution
    bod_op_t              op;         // decoded operation class
    logic [FADDR_W-1:0]   f_addr;     // named file register
    logic [BITPOS_W-1:0]  bit_pos;    // selected bit
    logic                 dest;       // 0 accumulator, 1 file register
    logic [REL_W-1:0]     rel;        // signed jump literal
    logic                 ptr_num;    // pointer pair number
    logic                 uses_file;  // instruction names a file register

    modport dec  (input word, output op, f_addr, bit_pos, dest, rel, ptr_num, uses_file);
    modport core (output word, input op, f_addr, bit_pos, dest, rel, ptr_num, uses_file);
endinterface : bod_dec_if

/* File: bod_field_dec.sv */
`timescale 1ns/1ps
// combinational operand and opcode decoder
module bod_field_dec
    import bod_pkg::*;
(
    bod_dec_if.dec d_if
);

    // operand fields; don't-care bits are simply never looked at
    always_comb begin
        d_if.f_addr  = d_if.word[F_LSB +: FADDR_W];
        d_if.bit_pos = d_if.word[BITPOS_LSB +: BITPOS_W];
        d_if.dest    = d_if.word[DEST_POS];
        d_if.rel     = d_if.word[REL_LSB +: REL_W];
        d_if.ptr_num = d_if.word[PTR_POS];
    end

    // opcode class by masked compare, anything unknown runs as idle
    always_comb begin
        if (bod_match(d_if.word, BITOP_MASK, BCLR_VAL)) begin
            d_if.op = bit_clear_op;
        end else if (bod_match(d_if.word, BITOP_MASK, SKZ_VAL)) begin
            d_if.op = skip_if_zero_op;
        end else if (bod_match(d_if.word, BITOP_MASK, SKO_VAL)) begin
            d_if.op = skip_if_one_op;
        end else if (bod_match(d_if.word, RJMP_MASK, RJMP_VAL)) begin
            d_if.op = relative_jump_op;
        end else if (bod_match(d_if.word, FCOPY_MASK, FCOPY_VAL)) begin
            d_if.op = file_copy_op;
        end else begin
            d_if.op = idle_op;
        end
        // every class that names a file register reads it
        d_if.uses_file = (d_if.op == bit_clear_op) || (d_if.op == skip_if_zero_op) ||
                         (d_if.op == skip_if_one_op) || (d_if.op == file_copy_op);
    end

endmodule : bod_field_dec

/* File: bod_core.sv */
`timescale 1ns/1ps
//Behaviour
// - file instructions read, modify, then store result
// - named register always read, even write-only
// - file select is seven bits, 0x00-0x7F
// - dest 0 to accumulator, 1 to file
// - bit position picks one of eight bits
// - don't-care instruction bits never affect execution
// - pointer number selects pair 0 or 1
// - bit clear zeroes one bit, flags untouched
// - skip-if-zero discards next when bit zero
// - skip-if-one discards next when bit one
// - relative jump adds signed nine-bit literal
// - jump target address+1+k, two cycles, flags untouched
// - each instruction is one fourteen-bit word
// - instruction cycle is four core clocks
module bod_core
    import bod_pkg::*;
#(
    parameter int unsigned PC_W = PC_W_DEF                  // program counter width
)(
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    output logic [PC_W-1:0]           fetch_addr_q,         // address being fetched
    input  wire logic [INSTR_W-1:0]   instr_word,           // fetched word, taken at end of last phase
    output logic                      fr_rd_en_q,           // file register read strobe
    output logic [FADDR_W-1:0]        fr_addr_q,            // file register address
    input  wire logic [DATA_W-1:0]    fr_rd_data,           // read data, the cycle after the strobe
    output logic                      fr_wr_en_q,           // file register write strobe
    output logic [DATA_W-1:0]         fr_wr_data_q,         // file register write data
    output logic                      acc_we_q,             // accumulator write strobe
    output logic [DATA_W-1:0]         acc_data_q,           // accumulator write data
    output logic                      ptr_sel_q,            // pointer pair of current instruction
    output logic                      discard_q             // current slot runs as idle
);

    bod_dec_if d_if ();                                     // decoder link

    logic [PC_W-1:0]      pc_q, pc_d;                       // already incremented program counter
    logic [INSTR_W-1:0]   ir_q, ir_d;                       // instruction under execution
    bod_phase_t           ph_q, ph_d;                       // phase within instruction cycle
    logic                 flush_q, flush_d;                 // this slot is discarded
    logic                 skip_q, skip_d;                   // next slot must be discarded
    // next values of the registered strobes, address and data outputs
    logic                 rd_d, wr_d, acc_d, ptr_d;
    logic [FADDR_W-1:0]   addr_d;
    logic [DATA_W-1:0]    wdat_d, adat_d;
    logic [PC_W-1:0]      rel_ext;                          // sign-extended jump literal

    // field decoder on the current word
    bod_field_dec u_dec (
        .d_if (d_if.dec)
    );

    assign d_if.word = ir_q;
    assign rel_ext   = {{(PC_W-REL_W){d_if.rel[REL_W-1]}}, d_if.rel};

    // next-state of phase, pc, instruction and file access strobes
    always_comb begin
        ph_d    = ph_q;
        pc_d    = pc_q;
        ir_d    = ir_q;
        flush_d = flush_q;
        skip_d  = skip_q;
        rd_d    = 1'b0;
        wr_d    = 1'b0;
        acc_d   = 1'b0;
        addr_d  = fr_addr_q;
        wdat_d  = fr_wr_data_q;
        adat_d  = acc_data_q;
        ptr_d   = ptr_sel_q;
        case (ph_q)
            // issue the read of the named register
            PH_DEC: begin
                ph_d   = PH_RD;
                ptr_d  = d_if.ptr_num;
                addr_d = d_if.f_addr;
                rd_d   = d_if.uses_file && !flush_q;
            end
            // data returns during the next phase
            PH_RD: begin
                ph_d = PH_MOD;
            end
            // modify and choose the destination
            PH_MOD: begin
                ph_d   = PH_WB;
                skip_d = 1'b0;
                if (!flush_q) begin
                    case (d_if.op)
                        bit_clear_op: begin
                            wr_d   = 1'b1;
                            wdat_d = fr_rd_data & ~(DATA_W'(1) << d_if.bit_pos);
                        end
                        skip_if_zero_op: begin
                            skip_d = !fr_rd_data[d_if.bit_pos];
                        end
                        skip_if_one_op: begin
                            skip_d = fr_rd_data[d_if.bit_pos];
                        end
                        file_copy_op: begin
                            if (d_if.dest) begin
                                wr_d   = 1'b1;
                                wdat_d = fr_rd_data;
                            end else begin
                                acc_d  = 1'b1;
                                adat_d = fr_rd_data;
                            end
                        end
                        default: begin
                            skip_d = 1'b0;
                        end
                    endcase
                end
            end
            // retire: take next word and move the pc
            default: begin
                ph_d = PH_DEC;
                ir_d = instr_word;
                // a taken jump throws away the word fetched behind it
                if (!flush_q && d_if.op == relative_jump_op) begin
                    pc_d    = pc_q + rel_ext;
                    flush_d = 1'b1;                         // prefetched word dropped
                end else begin
                    pc_d    = pc_q + PC_W'(1);
                    flush_d = skip_q;
                end
            end
        endcase
    end

    // register everything; outputs all come from here
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q         <= PH_DEC;
            pc_q         <= '0;
            ir_q         <= IR_RST;
            flush_q      <= 1'b0;
            skip_q       <= 1'b0;
            fr_rd_en_q   <= 1'b0;
            fr_wr_en_q   <= 1'b0;
            acc_we_q     <= 1'b0;
            fr_addr_q    <= FADDR_RST;
            fr_wr_data_q <= DATA_RST;
            acc_data_q   <= DATA_RST;
            ptr_sel_q    <= 1'b0;
        end else begin
            ph_q         <= ph_d;
            pc_q         <= pc_d;
            ir_q         <= ir_d;
            flush_q      <= flush_d;
            skip_q       <= skip_d;
            fr_rd_en_q   <= rd_d;
            fr_wr_en_q   <= wr_d;
            acc_we_q     <= acc_d;
            fr_addr_q    <= addr_d;
            fr_wr_data_q <= wdat_d;
            acc_data_q   <= adat_d;
            ptr_sel_q    <= ptr_d;
        end
    end

    assign fetch_addr_q = pc_q;                             // straight from the pc register
    assign discard_q    = flush_q;

    // checks on the instruction cycle
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    rd_before_wr_a: assert property (fr_wr_en_q |-> $past(fr_rd_en_q, 2))
        else $error("file write without preceding read");

    same_addr_a: assert property (fr_wr_en_q |-> fr_addr_q == $past(fr_addr_q, 2))
        else $error("write address differs from read address");

    bit_clear_a: assert property (fr_wr_en_q && d_if.op == bit_clear_op
            |-> fr_wr_data_q == ($past(fr_rd_data) & ~(DATA_W'(1) << d_if.bit_pos)))
        else $error("bit clear result wrong");

    dest_acc_a: assert property (acc_we_q |-> !d_if.dest && d_if.op == file_copy_op)
        else $error("accumulator written with dest one");

    phase_cycle_a: assert property (ph_q == PH_DEC |=> ph_q == PH_RD ##1 ph_q == PH_MOD
            ##1 ph_q == PH_WB ##1 ph_q == PH_DEC)
        else $error("instruction cycle not four clocks");

    discard_quiet_a: assert property (flush_q |-> !fr_rd_en_q && !fr_wr_en_q && !acc_we_q)
        else $error("discarded slot touched registers");

    skip_zero_a: assert property (ph_q == PH_MOD && !flush_q && d_if.op == skip_if_zero_op
            |=> skip_q == !$past(fr_rd_data[d_if.bit_pos]) ##1 flush_q == skip_q)
        else $error("skip if zero decision wrong");

    skip_one_a: assert property (ph_q == PH_MOD && !flush_q && d_if.op == skip_if_one_op
            |=> skip_q == $past(fr_rd_data[d_if.bit_pos]))
        else $error("skip if one decision wrong");

    jump_target_a: assert property (ph_q == PH_WB && !flush_q && d_if.op == relative_jump_op
            |=> pc_q == $past(pc_q) + $past(rel_ext) && flush_q)
        else $error("relative jump target wrong");

    seq_pc_a: assert property (ph_q == PH_WB && (flush_q || d_if.op != relative_jump_op)
            |=> pc_q == $past(pc_q) + PC_W'(1))
        else $error("pc did not advance by one");

    // a read belongs to a file instruction and lasts one clock
    rd_file_only_a: assert property (fr_rd_en_q |-> ph_q == PH_RD && d_if.uses_file)
        else $error("read strobe outside a file instruction");

    rd_pulse_a: assert property (fr_rd_en_q |=> !fr_rd_en_q)
        else $error("read strobe longer than one clock");

    // a result goes to exactly one destination
    one_dest_a: assert property (!(fr_wr_en_q && acc_we_q))
        else $error("file and accumulator written together");

    // main scenarios seen at least once
    bclr_seen_c: cover property (fr_wr_en_q && d_if.op == bit_clear_op);
    skip_taken_c: cover property (ph_q == PH_DEC && flush_q);
    jump_seen_c: cover property (ph_q == PH_WB && !flush_q && d_if.op == relative_jump_op);
    skip_one_c: cover property (ph_q == PH_MOD && !flush_q && d_if.op == skip_if_one_op
            && fr_rd_data[d_if.bit_pos]);
    acc_write_c: cover property (acc_we_q);

endmodule : bod_core

/* File: bod_partner.sv */
`timescale 1ns/1ps
// program memory and file register space facing the core
module bod_partner
    import bod_pkg::*;
#(
    parameter int unsigned PC_W = PC_W_DEF          // program counter width
)(
    input  wire logic               core_clk,
    input  wire logic [PC_W-1:0]    fetch_addr,
    output logic [INSTR_W-1:0]      instr_word,
    input  wire logic               fr_rd_en,
    input  wire logic [FADDR_W-1:0] fr_addr,
    output logic [DATA_W-1:0]       fr_rd_data,
    input  wire logic               fr_wr_en,
    input  wire logic [DATA_W-1:0]  fr_wr_data
);
    logic [INSTR_W-1:0] prog [0:511];               // program words, loaded by the bench
    logic [DATA_W-1:0]  fmem [0:127];               // file registers
    logic [DATA_W-1:0]  rd_q = 8'h00;               // last value read
    logic               vld_q = 1'b0;               // read data is due this cycle
    // one whole word for the address being fetched
    assign instr_word = prog[fetch_addr[8:0]];
    // data only in the cycle after the strobe, garbage otherwise
    assign fr_rd_data = vld_q ? rd_q : ~rd_q;
    // read and write ports of the register space
    always @(posedge core_clk) begin
        vld_q <= fr_rd_en;
        if (fr_rd_en) begin
            rd_q <= fmem[fr_addr];
        end
        if (fr_wr_en) begin
            fmem[fr_addr] <= fr_wr_data;
        end
    end
endmodule : bod_partner

/* File: bod_core_bench.sv */
`timescale 1ns/1ps
// self-checking bench for the bit-op and jump core
module bod_core_bench import bod_pkg::*;;
    // one row: word, register before, register after, acc write, skip
    typedef struct packed {
        logic [13:0] word;
        logic [7:0]  init;
        logic [7:0]  expf;
        logic [8:0]  expacc;
        logic        skip;
    } bod_row_t;
    localparam bod_row_t ROWS [9] = '{
        '{14'h1185, 8'hff, 8'hf7, 9'h000, 1'b0},    // clear bit 3 of 0x05
        '{14'h13ff, 8'hff, 8'h7f, 9'h000, 1'b0},    // clear bit 7 of 0x7f
        '{14'h1820, 8'h01, 8'h01, 9'h000, 1'b0},    // skip-if-zero, bit set
        '{14'h1ba0, 8'h7f, 8'h7f, 9'h000, 1'b1},    // skip-if-zero, bit clear
        '{14'h1d21, 8'h04, 8'h04, 9'h000, 1'b1},    // skip-if-one, bit set
        '{14'h1d21, 8'hfb, 8'hfb, 9'h000, 1'b0},    // skip-if-one, bit clear
        '{14'h0830, 8'ha5, 8'ha5, 9'h1a5, 1'b0},    // copy to accumulator
        '{14'h08b0, 8'h5a, 8'h5a, 9'h000, 1'b0},    // copy back to register
        '{14'h3fff, 8'h3c, 8'h3c, 9'h000, 1'b0}     // unknown opcode runs idle
    };
    logic                core_clk = 1'b0;           // 200 MHz core clock
    logic                rst_n    = 1'b0;           // async reset, active low
    logic [PC_W_DEF-1:0] fetch_addr_q;
    logic [13:0]         instr_word;
    logic                fr_rd_en_q, fr_wr_en_q, acc_we_q, ptr_sel_q, discard_q;
    logic [6:0]          fr_addr_q, rd_addr;
    logic [7:0]          fr_rd_data, fr_wr_data_q, acc_data_q, acc_seen;
    int                  err_total = 0, tests_run = 0, cyc = 0, rd_cyc = 0, n_acc = 0, n_disc = 0;
    bod_core #(.PC_W(PC_W_DEF)) bod_core_inst (.core_clk(core_clk), .rst_n(rst_n),
        .fetch_addr_q(fetch_addr_q), .instr_word(instr_word), .fr_rd_en_q(fr_rd_en_q),
        .fr_addr_q(fr_addr_q), .fr_rd_data(fr_rd_data), .fr_wr_en_q(fr_wr_en_q),
        .fr_wr_data_q(fr_wr_data_q), .acc_we_q(acc_we_q), .acc_data_q(acc_data_q),
        .ptr_sel_q(ptr_sel_q), .discard_q(discard_q));
    bod_partner #(.PC_W(PC_W_DEF)) bod_partner_inst (.core_clk(core_clk), .fetch_addr(fetch_addr_q),
        .instr_word(instr_word), .fr_rd_en(fr_rd_en_q), .fr_addr(fr_addr_q), .fr_rd_data(fr_rd_data),
        .fr_wr_en(fr_wr_en_q), .fr_wr_data(fr_wr_data_q));
    // clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    // compare and count
    task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // print counts and verdict, then stop
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    // cuts a hang short: the whole run needs well under this many clocks
    initial begin
        repeat (2000) @(posedge core_clk);
        err_total++;
        summarize();
    end
    // watches strobes every cycle
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (fr_rd_en_q) begin
            rd_cyc  <= cyc;
            rd_addr <= fr_addr_q;
            check("ptr_sel", ptr_sel_q, fr_addr_q[2]);
        end
        if (fr_wr_en_q) begin
            check("wr_addr", fr_addr_q, rd_addr);
            check("rd_to_wr", cyc - rd_cyc, 2);
        end
        if (acc_we_q) begin
            n_acc    <= n_acc + 1;
            acc_seen <= acc_data_q;
        end
        if (discard_q) begin
            n_disc <= n_disc + 1;
            check("strobe_in_discard", {fr_rd_en_q, fr_wr_en_q, acc_we_q}, 0);
        end
    end
    // hold reset 8 cycles, check the reset state, load an idle program with a bit clear of 0x10 at address 1
    task automatic start();
        rst_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        check("rst_state", {fetch_addr_q, fr_rd_en_q, fr_wr_en_q, acc_we_q, discard_q}, 0);
        for (int i = 0; i < 512; i++) begin
            bod_partner_inst.prog[i] = 14'h0000;
        end
        bod_partner_inst.prog[1] = 14'h1010;
        bod_partner_inst.fmem[7'h10] = 8'hff;
        n_acc    = 0;
        n_disc   = 0;
        acc_seen = 8'h00;
    endtask : start
    // release reset and run whole instruction slots
    task automatic go(input int slots);
        rst_n <= 1'b1;
        repeat (CLK_PER_ICYC * slots) @(posedge core_clk);
    endtask : go
    // main sequence
    initial begin
        for (int r = 0; r < 9; r++) begin
            start();
            bod_partner_inst.prog[0] = ROWS[r].word;
            bod_partner_inst.fmem[ROWS[r].word[6:0]] = ROWS[r].init;
            go(5);
            check("file_reg", bod_partner_inst.fmem[ROWS[r].word[6:0]], ROWS[r].expf);
            check("acc", {n_acc != 0, acc_seen}, ROWS[r].expacc);
            check("marker", bod_partner_inst.fmem[7'h10], ROWS[r].skip ? 8'hff : 8'hfe);
            check("discards", n_disc, ROWS[r].skip ? CLK_PER_ICYC : 0);
        end
        // jump +255 to 0x100, then -256 back to 0x001
        start();
        bod_partner_inst.prog[0] = 14'h32ff;
        bod_partner_inst.prog[1] = 14'h1011;
        bod_partner_inst.prog[9'h100] = 14'h3300;
        bod_partner_inst.prog[9'h101] = 14'h1013;
        bod_partner_inst.fmem[7'h11] = 8'hff;
        bod_partner_inst.fmem[7'h13] = 8'hff;
        go(7);
        check("jump_back", bod_partner_inst.fmem[7'h11], 8'hfe);
        check("jump_slot", bod_partner_inst.fmem[7'h13], 8'hff);
        check("jump_discards", n_disc, 8);
        // reset as a bit clear enters write-back: the write must not land
        start();
        bod_partner_inst.prog[0] = 14'h1010;
        rst_n <= 1'b1;
        repeat (7) @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("cut_write", bod_partner_inst.fmem[7'h10], 8'hff);
        // second release in mid-run: idle slot first, then address 0 onwards
        start();
        go(4);
        check("restart_run", bod_partner_inst.fmem[7'h10], 8'hfe);
        check("restart_discards", n_disc, 0);
        summarize();
    end
endmodule : bod_core_bench
